// File: core/fsr_pkg.sv
package fsr_pkg;

    // ------------------------------------------------------------
    // register offsets (quadlet port byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  FSR_QSTAT_OFS  = 8'h30;
    localparam logic [7:0]  FSR_BRST_OFS   = 8'h34;
    localparam logic [7:0]  FSR_CMDW0_OFS  = 8'h38;
    localparam logic [7:0]  FSR_CMDW1_OFS  = 8'h3C;
    localparam logic [7:0]  FSR_CMDW2_OFS  = 8'h40;
    localparam logic [7:0]  FSR_RSVD_LO    = 8'h44;
    localparam logic [7:0]  FSR_RSVD_HI    = 8'h48;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] FSR_WORD_RST   = 32'h00000000;
    localparam logic [9:0]  FSR_BUS_ID_RST = 10'h000;
    localparam logic [9:0]  FSR_BUS_ID_ALL = 10'h3FF;

    // ------------------------------------------------------------
    // queue_status fields, hardware bit = 31 - printed bit
    // ------------------------------------------------------------
    localparam int QS_TX_FREE_LSB  = 24;  // printed 00-07
    localparam int QS_TX_FLUSH     = 23;  // printed 08
    localparam int QS_TX_WBE       = 22;  // printed 09
    localparam int QS_TX_FULL      = 21;  // printed 10
    localparam int QS_TX_ACK_LSB   = 16;  // printed 11-15
    localparam int QS_RX_XBIT      = 15;  // printed 16
    localparam int QS_RX_FLUSH     = 14;  // printed 17
    localparam int QS_RX_RBE       = 13;  // printed 18
    localparam int QS_ST_FLUSH     = 12;  // printed 19
    localparam int QS_ST_CNT_LSB   = 8;   // printed 20-23
    localparam int QS_RX_CNT_LSB   = 0;   // printed 24-31

    // ------------------------------------------------------------
    // bus_reset_info fields
    // ------------------------------------------------------------
    localparam int BR_VALID        = 31;  // printed 00
    localparam int BR_NODES_LSB    = 24;  // printed 02-07
    localparam int BR_ROOT         = 23;  // printed 08
    localparam int BR_BUS_ID_LSB   = 6;   // printed 16-25
    localparam int BR_NODE_LSB     = 0;   // printed 26-31

    // ------------------------------------------------------------
    // command packet byte lanes inside a word
    // ------------------------------------------------------------
    localparam int LANE_N0_LSB     = 16;  // byte n
    localparam int LANE_N1_LSB     = 24;  // byte n+1
    localparam int LANE_N2_LSB     = 0;   // byte n+2
    localparam int LANE_N3_LSB     = 8;   // byte n+3
    localparam logic [3:0] FSR_PKT_LAST = 4'hB;  // twelve bytes

    // ------------------------------------------------------------
    // empty-queue values after a flush
    // ------------------------------------------------------------
    localparam logic [7:0]  FSR_RX_CNT_EMPTY = 8'h00;
    localparam logic [3:0]  FSR_ST_CNT_EMPTY = 4'h0;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CMD,
        SEQ_PKT
    } fsr_seq_type;

endpackage

// File: core/fsr_cmd_if.sv
`timescale 1ns/1ps
interface fsr_cmd_if;
    logic [95:0] words;  // {word2, word1, word0}
    logic        start;
    logic        done;

    modport seq  (output words, output start, input done);
    modport strm (input words, input start, output done);
endinterface

// File: core/fsr_pkt_stream.sv
`timescale 1ns/1ps
module fsr_pkt_stream
(
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    // packet words from the register bank
    fsr_cmd_if.strm    cmd,
    // byte stream toward the drive
    output logic [7:0] pkt_byte_out,
    output logic       pkt_valid_out,
    input  wire logic  pkt_ready_in
);
    import fsr_pkg::*;

    logic [95:0] snap_r;
    logic [3:0]  idx_r;
    logic        act_r;
    logic [7:0]  byte_r;
    logic        step;

    // byte i of the packet from the packed words
    function automatic logic [7:0] pick(input logic [95:0] w, input logic [3:0] i);
        logic [31:0] q;
        q = w[{i[3:2], 5'h00} +: 32];
        unique case (i[1:0])
            2'h0: pick = q[LANE_N0_LSB +: 8];
            2'h1: pick = q[LANE_N1_LSB +: 8];
            2'h2: pick = q[LANE_N2_LSB +: 8];
            2'h3: pick = q[LANE_N3_LSB +: 8];
        endcase
    endfunction

    assign step = act_r & pkt_ready_in;

    // snapshot and byte index
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            snap_r <= 96'h0;
            idx_r  <= 4'h0;
            act_r  <= 1'b0;
        end else if (!act_r && cmd.start) begin
            snap_r <= cmd.words;
            idx_r  <= 4'h0;
            act_r  <= 1'b1;
        end else if (step) begin
            idx_r <= idx_r + 4'h1;
            if (idx_r == FSR_PKT_LAST) begin
                act_r <= 1'b0;
            end
        end
    end

    // registered byte lane, bytes 0..11 in order
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            byte_r <= 8'h00;
        end else if (!act_r && cmd.start) begin
            byte_r <= pick(cmd.words, 4'h0);
        end else if (step && idx_r != FSR_PKT_LAST) begin
            byte_r <= pick(snap_r, idx_r + 4'h1);
        end
    end

    assign pkt_byte_out  = byte_r;
    assign pkt_valid_out = act_r;
    assign cmd.done      = step && (idx_r == FSR_PKT_LAST);

endmodule

// File: core/fsr_regs.sv
`timescale 1ns/1ps
// Contract
// - async_tx_queue free quadlets shown in 8-bit read-only field.
// - writing one to tx_fifo_flush empties the async_tx_queue.
// - tx_write_stage_empty reads one when the four-quadlet staging buffer is empty.
// - tx_fifo_full_flag reads one while the async_tx_queue has no room.
// - each arriving transmit acknowledge loads the 5-bit tx_ack_code field.
// - each general_rx_queue read copies the entry's 33rd bit into rx_extra_bit_flag.
// - writing one to rx_fifo_flush empties the general_rx_queue.
// - rx_read_stage_empty reads one when the four-quadlet read buffer is empty.
// - writing one to stat_queue_flush empties the status queue.
// - status queue occupied quadlets shown in 4-bit read-only field.
// - general_rx_queue occupied quadlets shown in 8-bit read-only field.
// - topology_info_valid reads one only while topology values are all valid.
// - number of nodes seen on the bus in 6-bit read-only field.
// - root bit reads one when the local node is root.
// - bus reset with bus_id_force set loads bus id 3FFh; field stays writable.
// - after every bus reset local_node_index loads the assigned node number.
// - twelve packet bytes in three words, lanes n+1, n, n+3, n+2.
// - packet is sent automatically only when seq_launch and full_auto_select are set.
// - every register bit is zero after reset.
// - addresses 44h to 48h are reserved and do nothing.
// - printed bit 00 is the word's most significant bit.
// - launch with auto runs command, packet, data phases; otherwise only data.
module fsr_regs
#(
    parameter logic [7:0] TX_DEPTH_QUADLETS = 8'hFF
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // firmware register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    // async transmit queue
    input  wire logic [7:0]  tx_free_in,
    input  wire logic        tx_wbuf_empty_in,
    input  wire logic        tx_full_in,
    input  wire logic        tx_ack_valid_in,
    input  wire logic [4:0]  tx_ack_code_in,
    output logic             tx_flush_out,
    // general receive queue
    input  wire logic        rx_pop_in,
    input  wire logic        rx_bit33_in,
    input  wire logic        rx_rbuf_empty_in,
    input  wire logic [7:0]  rx_used_in,
    output logic             rx_flush_out,
    // status queue
    input  wire logic [3:0]  stat_used_in,
    output logic             stat_flush_out,
    // serial bus reset and topology
    input  wire logic        bus_reset_in,
    input  wire logic        topo_done_in,
    input  wire logic [5:0]  node_number_in,
    input  wire logic [5:0]  nodes_seen_in,
    input  wire logic        root_in,
    input  wire logic        bus_id_force_in,
    // command sequencer
    input  wire logic        seq_launch_in,
    input  wire logic        full_auto_select_in,
    input  wire logic        cmd_phase_done_in,
    output logic             cmd_phase_start_out,
    output logic             data_phase_start_out,
    output logic             seq_busy_out,
    // command packet stream to the drive
    output logic [7:0]       pkt_byte_out,
    output logic             pkt_valid_out,
    input  wire logic        pkt_ready_in
);
    import fsr_pkg::*;

    // register write decode
    logic        wr_qstat;
    logic        wr_brst;
    logic [2:0]  wr_cmdw;
    // queue flush strobes
    logic        tx_flush_r;
    logic        rx_flush_r;
    logic        st_flush_r;
    // mirrored queue state
    logic [7:0]  tx_free_r;
    logic        tx_wbe_r;
    logic        tx_full_r;
    logic [4:0]  tx_ack_r;
    logic        rx_xbit_r;
    logic        rx_rbe_r;
    logic [7:0]  rx_used_r;
    logic [3:0]  st_used_r;
    // topology state
    logic        topo_valid_r;
    logic [5:0]  nodes_r;
    logic        root_r;
    logic [9:0]  bus_id_r;
    logic [5:0]  node_idx_r;
    // command packet words
    logic [31:0] cmdw_r [3];
    // sequencer
    fsr_seq_type seq_r;
    fsr_seq_type seq_nxt;
    logic        cmd_start_r;
    logic        data_start_r;
    logic        pkt_go;
    // read path
    logic [31:0] qstat_word;
    logic [31:0] brst_word;
    logic [31:0] rd_mux;
    logic [31:0] rdata_r;
    // link to packet streamer
    fsr_cmd_if   cmd_link ();

    // ------------------------
    // address decode
    // ------------------------
    // one strobe per register; reserved and unmapped do nothing
    assign wr_qstat   = reg_wr_in && (reg_addr_in == FSR_QSTAT_OFS);
    assign wr_brst    = reg_wr_in && (reg_addr_in == FSR_BRST_OFS);
    assign wr_cmdw[0] = reg_wr_in && (reg_addr_in == FSR_CMDW0_OFS);
    assign wr_cmdw[1] = reg_wr_in && (reg_addr_in == FSR_CMDW1_OFS);
    assign wr_cmdw[2] = reg_wr_in && (reg_addr_in == FSR_CMDW2_OFS);

    // ------------------------
    // queue flush controls
    // ------------------------
    // write-one flush bits, each held for one cycle only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_flush_r <= 1'b0;
            rx_flush_r <= 1'b0;
            st_flush_r <= 1'b0;
        end else begin
            tx_flush_r <= wr_qstat && reg_wdata_in[QS_TX_FLUSH];
            rx_flush_r <= wr_qstat && reg_wdata_in[QS_RX_FLUSH];
            st_flush_r <= wr_qstat && reg_wdata_in[QS_ST_FLUSH];
        end
    end
    assign tx_flush_out   = tx_flush_r;
    assign rx_flush_out   = rx_flush_r;
    assign stat_flush_out = st_flush_r;

    // ------------------------
    // transmit queue status
    // ------------------------
    // free space and flags tracked, forced empty on flush
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_free_r <= 8'h00;
            tx_wbe_r  <= 1'b0;
            tx_full_r <= 1'b0;
        end else if (tx_flush_r) begin
            tx_free_r <= TX_DEPTH_QUADLETS;
            tx_wbe_r  <= 1'b1;
            tx_full_r <= 1'b0;
        end else begin
            tx_free_r <= tx_free_in;
            tx_wbe_r  <= tx_wbuf_empty_in;
            tx_full_r <= tx_full_in;
        end
    end
    // acknowledge code, held until the next one
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_ack_r <= 5'h00;
        end else if (tx_ack_valid_in) begin
            tx_ack_r <= tx_ack_code_in;
        end
    end

    // ------------------------
    // receive and status queues
    // ------------------------
    // extra bit follows every queue read
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_xbit_r <= 1'b0;
        end else if (rx_pop_in) begin
            rx_xbit_r <= rx_bit33_in;
        end
    end
    // occupancy and read buffer flag
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_rbe_r  <= 1'b0;
            rx_used_r <= 8'h00;
        end else if (rx_flush_r) begin
            rx_rbe_r  <= 1'b1;
            rx_used_r <= FSR_RX_CNT_EMPTY;
        end else begin
            rx_rbe_r  <= rx_rbuf_empty_in;
            rx_used_r <= rx_used_in;
        end
    end
    // status queue occupancy, forced empty on flush
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_used_r <= 4'h0;
        end else if (st_flush_r) begin
            st_used_r <= FSR_ST_CNT_EMPTY;
        end else begin
            st_used_r <= stat_used_in;
        end
    end

    // ------------------------
    // topology capture
    // ------------------------
    // valid drops at bus reset, rises once topology is known
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            topo_valid_r <= 1'b0;
            nodes_r      <= 6'h00;
            root_r       <= 1'b0;
            node_idx_r   <= 6'h00;
        end else if (bus_reset_in) begin
            topo_valid_r <= 1'b0;
        end else if (topo_done_in) begin
            topo_valid_r <= 1'b1;
            nodes_r      <= nodes_seen_in;
            root_r       <= root_in;
            node_idx_r   <= node_number_in;
        end else if (wr_brst) begin
            node_idx_r   <= reg_wdata_in[BR_NODE_LSB +: 6];
        end
    end
    // bus id: forced on bus reset with bus_id_force set, otherwise writable
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_id_r <= FSR_BUS_ID_RST;
        end else if (bus_reset_in && bus_id_force_in) begin
            bus_id_r <= FSR_BUS_ID_ALL;
        end else if (wr_brst) begin
            bus_id_r <= reg_wdata_in[BR_BUS_ID_LSB +: 10];
        end
    end

    // ------------------------
    // command packet words
    // ------------------------
    // three plain read/write words
    for (genvar w = 0; w < 3; w++) begin : g_cmdw
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                cmdw_r[w] <= FSR_WORD_RST;
            end else if (wr_cmdw[w]) begin
                cmdw_r[w] <= reg_wdata_in;
            end
        end
    end

    // ------------------------
    // launch sequencer
    // ------------------------
    // next state; launches while busy are dropped
    always_comb begin
        seq_nxt = seq_r;
        pkt_go  = 1'b0;
        unique case (seq_r)
            SEQ_IDLE: begin
                if (seq_launch_in && full_auto_select_in) begin
                    seq_nxt = SEQ_CMD;
                end
            end
            SEQ_CMD: begin
                if (cmd_phase_done_in) begin
                    seq_nxt = SEQ_PKT;
                    pkt_go  = 1'b1;
                end
            end
            SEQ_PKT: begin
                if (cmd_link.done) begin
                    seq_nxt = SEQ_IDLE;
                end
            end
        endcase
    end
    // state register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seq_r <= SEQ_IDLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end
    // phase start pulses
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_start_r  <= 1'b0;
            data_start_r <= 1'b0;
        end else begin
            cmd_start_r  <= (seq_r == SEQ_IDLE) && seq_launch_in && full_auto_select_in;
            data_start_r <= ((seq_r == SEQ_IDLE) && seq_launch_in && !full_auto_select_in)
                            || ((seq_r == SEQ_PKT) && cmd_link.done);
        end
    end
    assign cmd_phase_start_out  = cmd_start_r;
    assign data_phase_start_out = data_start_r;
    assign seq_busy_out         = (seq_r != SEQ_IDLE);

    // ------------------------
    // packet streamer
    // ------------------------
    assign cmd_link.words = {cmdw_r[2], cmdw_r[1], cmdw_r[0]};
    assign cmd_link.start = pkt_go;
    fsr_pkt_stream u_stream (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .cmd           (cmd_link.strm),
        .pkt_byte_out  (pkt_byte_out),
        .pkt_valid_out (pkt_valid_out),
        .pkt_ready_in  (pkt_ready_in)
    );

    // ------------------------
    // read path
    // ------------------------
    // queue_status assembly, printed bit 00 at bit 31
    always_comb begin
        qstat_word                             = FSR_WORD_RST;
        qstat_word[QS_TX_FREE_LSB +: 8]        = tx_free_r;
        qstat_word[QS_TX_FLUSH]                = tx_flush_r;
        qstat_word[QS_TX_WBE]                  = tx_wbe_r;
        qstat_word[QS_TX_FULL]                 = tx_full_r;
        qstat_word[QS_TX_ACK_LSB +: 5]         = tx_ack_r;
        qstat_word[QS_RX_XBIT]                 = rx_xbit_r;
        qstat_word[QS_RX_FLUSH]                = rx_flush_r;
        qstat_word[QS_RX_RBE]                  = rx_rbe_r;
        qstat_word[QS_ST_FLUSH]                = st_flush_r;
        qstat_word[QS_ST_CNT_LSB +: 4]         = st_used_r;
        qstat_word[QS_RX_CNT_LSB +: 8]         = rx_used_r;
    end
    // bus_reset_info assembly, reserved bits zero
    always_comb begin
        brst_word                              = FSR_WORD_RST;
        brst_word[BR_VALID]                    = topo_valid_r;
        brst_word[BR_NODES_LSB +: 6]           = nodes_r;
        brst_word[BR_ROOT]                     = root_r;
        brst_word[BR_BUS_ID_LSB +: 10]         = bus_id_r;
        brst_word[BR_NODE_LSB +: 6]            = node_idx_r;
    end
    // offset select; reserved range and unmapped read zero
    always_comb begin
        unique case (reg_addr_in)
            FSR_QSTAT_OFS: rd_mux = qstat_word;
            FSR_BRST_OFS:  rd_mux = brst_word;
            FSR_CMDW0_OFS: rd_mux = cmdw_r[0];
            FSR_CMDW1_OFS: rd_mux = cmdw_r[1];
            FSR_CMDW2_OFS: rd_mux = cmdw_r[2];
            default:       rd_mux = FSR_WORD_RST;
        endcase
    end
    // read data register, held between reads
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r <= FSR_WORD_RST;
        end else if (reg_rd_in) begin
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata_out = rdata_r;

endmodule

// File: sim/fsr_regs_asserts.sv
`timescale 1ns/1ps
module fsr_regs_chk
    import fsr_pkg::*;
(
    // clock, reset, register port
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    // flush strobes
    input wire logic        tx_flush_out,
    input wire logic        rx_flush_out,
    input wire logic        stat_flush_out,
    // sequencer and packet stream
    input wire logic        seq_launch_in,
    input wire logic        full_auto_select_in,
    input wire logic        seq_busy_out,
    input wire logic        cmd_phase_start_out,
    input wire logic        data_phase_start_out,
    input wire logic [7:0]  pkt_byte_out,
    input wire logic        pkt_valid_out,
    input wire logic        pkt_ready_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // write to the queue status word
    wire q_wr = reg_wr_in && (reg_addr_in == FSR_QSTAT_OFS);
    wire r_rd = reg_rd_in && (reg_addr_in == FSR_RSVD_LO || reg_addr_in == FSR_RSVD_HI);
    a_tx_flush_pulse: assert property (q_wr && reg_wdata_in[QS_TX_FLUSH] |=> tx_flush_out)
        else $error("tx flush missing");
    a_tx_flush_cause: assert property ($rose(tx_flush_out) |-> $past(q_wr))
        else $error("tx flush without write");
    a_rx_flush_pulse: assert property (q_wr && reg_wdata_in[QS_RX_FLUSH] |=> rx_flush_out)
        else $error("rx flush missing");
    a_st_flush_pulse: assert property (q_wr && reg_wdata_in[QS_ST_FLUSH] |=> stat_flush_out)
        else $error("status flush missing");
    a_auto_launch: assert property (seq_launch_in && full_auto_select_in && !seq_busy_out
        |=> cmd_phase_start_out && seq_busy_out) else $error("auto launch wrong");
    a_data_launch: assert property (seq_launch_in && !full_auto_select_in && !seq_busy_out
        |=> data_phase_start_out && !cmd_phase_start_out) else $error("data launch wrong");
    a_pkt_hold: assert property (pkt_valid_out && !pkt_ready_in |=> pkt_valid_out && $stable(pkt_byte_out))
        else $error("packet byte moved while stalled");
    a_pkt_in_seq: assert property (pkt_valid_out |-> seq_busy_out)
        else $error("packet byte outside sequence");
    a_seq_end: assert property ($fell(seq_busy_out) |-> data_phase_start_out)
        else $error("data phase not started");
    a_rsvd_read: assert property (r_rd |=> reg_rdata_out == FSR_WORD_RST)
        else $error("reserved read not zero");
    c_auto: cover property (seq_launch_in && full_auto_select_in);
    c_stall: cover property (pkt_valid_out && !pkt_ready_in);
    c_flush: cover property (tx_flush_out && rx_flush_out && stat_flush_out);
endmodule

bind fsr_regs fsr_regs_chk i_chk (.*);

// File: sim/fsr_drive_model.sv
`timescale 1ns/1ps
module fsr_drive_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // command phase and packet bytes
    input  wire logic       cmd_start_in,
    input  wire logic       slow_in,
    output logic            cmd_done_out,
    input  wire logic [7:0] byte_in,
    input  wire logic       valid_in,
    output logic            ready_out
);
    logic [7:0] got_r [0:11];
    logic [3:0] cnt_r;
    logic [1:0] dly_r;
    // command phase ends two cycles after its start
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dly_r <= 2'h0;
        end else begin
            dly_r <= {dly_r[0], cmd_start_in};
        end
    end
    assign cmd_done_out = dly_r[1];
    // take bytes, stalling every other cycle when slow
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r     <= 4'h0;
            ready_out <= 1'b0;
        end else begin
            ready_out <= slow_in ? !ready_out : 1'b1;
            if (valid_in && ready_out) begin
                got_r[cnt_r] <= byte_in;
                cnt_r        <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fsr_pkg::*;
    localparam logic [7:0] TXD = 8'hFF;
    logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, tx_wbuf_empty_in, tx_full_in, tx_ack_valid_in, slow;
    logic        rx_pop_in, rx_bit33_in, rx_rbuf_empty_in, bus_reset_in, topo_done_in, root_in, bus_id_force_in;
    logic        seq_launch_in, full_auto_select_in, cmd_phase_done_in, pkt_ready_in, pkt_valid_out, seq_busy_out;
    logic        tx_flush_out, rx_flush_out, stat_flush_out, cmd_phase_start_out, data_phase_start_out;
    logic [31:0] reg_wdata_in, reg_rdata_out, rv;
    logic [7:0]  reg_addr_in, tx_free_in, rx_used_in, pkt_byte_out;
    logic [5:0]  node_number_in, nodes_seen_in;
    logic [4:0]  tx_ack_code_in;
    logic [3:0]  stat_used_in;
    int          failures, tests_run, cyc;

    fsr_regs #(.TX_DEPTH_QUADLETS(TXD)) i_dut (.*);
    fsr_drive_model i_drv (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_start_in(cmd_phase_start_out),
        .slow_in(slow), .cmd_done_out(cmd_phase_done_in), .byte_in(pkt_byte_out),
        .valid_in(pkt_valid_out), .ready_out(pkt_ready_in));

    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_in);
        #1 chk(reg_rdata_out, exp, nm);
    endtask
    function automatic logic [31:0] pw(int w);
        logic [7:0] b;
        b = 8'h10 + 8'(4 * w);
        return {b + 8'h1, b, b + 8'h3, b + 8'h2};
    endfunction
    task automatic wrap_up;
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, tx_free_in, tx_wbuf_empty_in, tx_full_in, slow} = '0;
        {tx_ack_valid_in, tx_ack_code_in, rx_pop_in, rx_bit33_in, rx_rbuf_empty_in, rx_used_in, stat_used_in} = '0;
        {bus_reset_in, topo_done_in, node_number_in, nodes_seen_in, root_in, bus_id_force_in} = '0;
        {seq_launch_in, full_auto_select_in, rstn_in, failures, tests_run, cyc} = '0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 5; i++) rchk(8'(8'h30 + 4 * i), FSR_WORD_RST, "reset word");
        @(posedge clk_in);
        {tx_free_in, tx_wbuf_empty_in, tx_full_in, tx_ack_valid_in, tx_ack_code_in} <= {8'hA5, 3'h7, 5'h13};
        {rx_pop_in, rx_bit33_in, rx_rbuf_empty_in, stat_used_in, rx_used_in} <= {3'h7, 4'h9, 8'h3C};
        @(posedge clk_in);
        {tx_ack_valid_in, rx_pop_in} <= 2'h0;
        rchk(FSR_QSTAT_OFS, {8'hA5, 3'h3, 5'h13, 4'hA, 4'h9, 8'h3C}, "queue status");
        wr(FSR_QSTAT_OFS, 32'h00805000);
        rchk(FSR_QSTAT_OFS, {TXD, 3'h2, 5'h13, 4'hA, 4'h0, 8'h00}, "after flush");
        wr(FSR_BRST_OFS, 32'h00005540);
        rchk(FSR_BRST_OFS, 32'h00005540, "bus id written");
        @(posedge clk_in);
        {bus_reset_in, bus_id_force_in, node_number_in, nodes_seen_in, root_in} <= {2'h3, 6'h2A, 6'h15, 1'b1};
        @(posedge clk_in);
        bus_reset_in <= 1'b0;
        rchk(FSR_BRST_OFS, 32'h0000FFC0, "after bus reset");
        @(posedge clk_in);
        topo_done_in <= 1'b1;
        @(posedge clk_in);
        topo_done_in <= 1'b0;
        rchk(FSR_BRST_OFS, {2'h2, 6'h15, 1'b1, 7'h00, 10'h3FF, 6'h2A}, "topology");
        wr(FSR_RSVD_LO, 32'hFFFFFFFF);
        wr(FSR_RSVD_HI, 32'hFFFFFFFF);
        rchk(FSR_RSVD_LO, FSR_WORD_RST, "reserved low");
        rchk(FSR_RSVD_HI, FSR_WORD_RST, "reserved high");
        for (int w = 0; w < 3; w++) wr(8'(FSR_CMDW0_OFS + 4 * w), pw(w));
        for (int w = 0; w < 3; w++) rchk(8'(FSR_CMDW0_OFS + 4 * w), pw(w), "packet word");
        @(posedge clk_in);
        seq_launch_in <= 1'b1;
        @(posedge clk_in);
        seq_launch_in <= 1'b0;
        #1 chk(32'({data_phase_start_out, seq_busy_out}), 32'h2, "data only launch");
        @(posedge clk_in);
        {slow, full_auto_select_in, seq_launch_in} <= 3'h7;
        @(posedge clk_in);
        seq_launch_in <= 1'b0;
        for (int i = 0; i < 200 && i_drv.cnt_r != 4'hC; i++) @(posedge clk_in);
        for (int k = 0; k < 12; k++) chk(32'(i_drv.got_r[k]), 32'(8'h10 + k), "packet byte");
        wrap_up();
    end
endmodule
